// *** rtl/aux_bus_bridge.sv ***
`timescale 1ns/100ps
module aux_bus_bridge (
	input wire logic core_clk,
	input wire logic rstn,
	aux_unit_bus_if.bridge_end bus0,
	aux_unit_bus_if.bridge_end bus1,
	input wire logic mmio_req,
	input wire logic mmio_write,
	input wire logic mmio_word,
	input wire logic [aux_bridge_pkg::MMIO_ADDR_W-1:0] mmio_addr,
	input wire logic [aux_bridge_pkg::HOST_DATA_W-1:0] mmio_wdata,
	output logic mmio_ack,
	output logic [aux_bridge_pkg::HOST_DATA_W-1:0] mmio_rdata,
	output logic dma_valid,
	output logic dma_write,
	output logic [aux_bridge_pkg::HOST_ADDR_W-1:0] dma_addr,
	output logic [aux_bridge_pkg::HOST_DATA_W-1:0] dma_wdata,
	input wire logic dma_done,
	input wire logic [aux_bridge_pkg::HOST_DATA_W-1:0] dma_rdata,
	input wire logic bus_error,
	input wire logic iso_in,
	output logic interrupt_req,
	output logic maint_interject,
	output logic op_interject
);
	aux_bridge_pkg::dma_state_t state;
	logic [aux_bridge_pkg::UPPER_W-1:0] upper_addr;
	logic bus_sel, diag_mode, diag_write, diag_pend, upper_loaded, err_flag, isolated;
	logic iso_valid, from_diag;
	logic [1:0] iso_pulse_q;
	logic [aux_bridge_pkg::AUX_ADDR_W-1:0] diag_addr;
	logic [aux_bridge_pkg::AUX_DATA_W-1:0] diag_data, iso_reply, dma_read, reply_q;
	logic [1:0] ack_q;

	// Selected bus; the other bus is ignored and gets no ack or pulse, but still sees the shared reply data
	wire sel_req = bus_sel ? bus1.dma_req : bus0.dma_req;
	wire sel_wr = bus_sel ? bus1.dma_write : bus0.dma_write;
	wire [aux_bridge_pkg::AUX_ADDR_W-1:0] sel_addr = bus_sel ? bus1.store_addr : bus0.store_addr;
	wire [aux_bridge_pkg::AUX_DATA_W-1:0] sel_data = bus_sel ? bus1.write_data : bus0.write_data;
	wire sel_op = bus_sel ? bus1.op_interject_req : bus0.op_interject_req;
	wire sel_maint = bus_sel ? bus1.maint_interject_req : bus0.maint_interject_req;
	wire sel_iso_v = bus_sel ? bus1.iso_reply_valid : bus0.iso_reply_valid;
	wire [aux_bridge_pkg::AUX_DATA_W-1:0] sel_iso = bus_sel ? bus1.iso_reply : bus0.iso_reply;

	wire mmio_take = mmio_req && !isolated;
	// Narrow accesses are acknowledged but change nothing and read zero
	wire mmio_wr = mmio_take && mmio_write && mmio_word;
	wire wr_upper = mmio_wr && (mmio_addr == aux_bridge_pkg::REG_UPPER_ADDR);
	wire wr_ctl = mmio_wr && (mmio_addr == aux_bridge_pkg::REG_CONTROL);
	wire wr_diag_a = mmio_wr && (mmio_addr == aux_bridge_pkg::REG_DIAG_ADDR);
	wire wr_diag_d = mmio_wr && (mmio_addr == aux_bridge_pkg::REG_DIAG_DATA);
	wire rd_iso = mmio_take && !mmio_write && mmio_word
		&& (mmio_addr == aux_bridge_pkg::REG_ISO_REPLY);
	wire rd_status = mmio_take && !mmio_write && mmio_word
		&& (mmio_addr == aux_bridge_pkg::REG_STATUS);
	wire [31:0] status_word = {27'h0, isolated, iso_valid, err_flag, upper_loaded,
		state != aux_bridge_pkg::ST_IDLE};
	wire [31:0] rd_word = !mmio_word ? 32'h0 :
		(mmio_addr == aux_bridge_pkg::REG_UPPER_ADDR) ? {24'h0, upper_addr} :
		(mmio_addr == aux_bridge_pkg::REG_CONTROL) ?
			{28'h0, diag_write, 1'b0, diag_mode, bus_sel} :
		(mmio_addr == aux_bridge_pkg::REG_STATUS) ? status_word :
		(mmio_addr == aux_bridge_pkg::REG_ISO_REPLY) ? {8'h00, iso_reply} :
		(mmio_addr == aux_bridge_pkg::REG_DIAG_ADDR) ? {10'h0, diag_addr} :
		(mmio_addr == aux_bridge_pkg::REG_DIAG_DATA) ? {8'h00, diag_data} :
		(mmio_addr == aux_bridge_pkg::REG_DMA_READ) ? {8'h00, dma_read} : 32'h0;

	// Client requests start only outside diagnostic mode; diagnostic starts only in diagnostic mode
	wire client_go = sel_req && !diag_mode;
	wire diag_go = diag_mode && diag_pend;
	// No transfer before the upper address has been written once
	// The request still stands while its ack does; a start there would move a second word
	wire dma_start = (state == aux_bridge_pkg::ST_IDLE) && !isolated && upper_loaded
		&& (client_go || diag_go) && (ack_q == 2'h0);
	wire start_wr = client_go ? sel_wr : diag_write;
	wire [aux_bridge_pkg::AUX_ADDR_W-1:0] start_addr = client_go ? sel_addr : diag_addr;
	wire [aux_bridge_pkg::AUX_DATA_W-1:0] start_data = client_go ? sel_data : diag_data;
	wire iso_go = wr_ctl && mmio_wdata[aux_bridge_pkg::CTL_ISO_SEND];
	// The pulse goes out on the bus chosen by the same control write
	wire next_sel = wr_ctl ? mmio_wdata[aux_bridge_pkg::CTL_BUS_SEL] : bus_sel;

	assign bus0.dma_ack = ack_q[0];
	assign bus1.dma_ack = ack_q[1];
	assign bus0.reply_data = reply_q;
	assign bus1.reply_data = reply_q;
	assign bus0.iso_pulse = iso_pulse_q[0];
	assign bus1.iso_pulse = iso_pulse_q[1];

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			upper_addr <= aux_bridge_pkg::UPPER_RESET;
			upper_loaded <= 1'b0;
		end else if (wr_upper) begin
			upper_addr <= mmio_wdata[aux_bridge_pkg::UPPER_W-1:0];
			upper_loaded <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			bus_sel <= 1'b0;
			diag_mode <= 1'b0;
			diag_write <= 1'b0;
			diag_addr <= '0;
			diag_data <= '0;
		end else begin
			if (wr_ctl) begin
				bus_sel <= mmio_wdata[aux_bridge_pkg::CTL_BUS_SEL];
				diag_mode <= mmio_wdata[aux_bridge_pkg::CTL_DIAG_MODE];
				diag_write <= mmio_wdata[aux_bridge_pkg::CTL_DIAG_WRITE];
			end
			if (wr_diag_a)
				diag_addr <= mmio_wdata[aux_bridge_pkg::AUX_ADDR_W-1:0];
			if (wr_diag_d)
				diag_data <= mmio_wdata[aux_bridge_pkg::AUX_DATA_W-1:0];
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			diag_pend <= 1'b0;
			iso_pulse_q <= 2'h0;
			iso_valid <= 1'b0;
			iso_reply <= '0;
			err_flag <= 1'b0;
			isolated <= 1'b0;
		end else begin
			if (wr_ctl && mmio_wdata[aux_bridge_pkg::CTL_DIAG_START])
				diag_pend <= 1'b1;
			else if (dma_start && !client_go)
				diag_pend <= 1'b0;
			iso_pulse_q <= {iso_go && next_sel, iso_go && !next_sel};
			// A reply arriving with the read that clears the flag is kept
			if (sel_iso_v && !isolated) begin
				iso_valid <= 1'b1;
				iso_reply <= sel_iso;
			end else if (rd_iso)
				iso_valid <= 1'b0;
			if (bus_error)
				err_flag <= 1'b1;
			else if (rd_status)
				err_flag <= 1'b0;
			// Isolation holds until reset
			if (iso_in)
				isolated <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			mmio_ack <= 1'b0;
			mmio_rdata <= '0;
			interrupt_req <= 1'b0;
			maint_interject <= 1'b0;
			op_interject <= 1'b0;
		end else begin
			mmio_ack <= mmio_take;
			mmio_rdata <= mmio_take && !mmio_write ? rd_word : 32'h0;
			interrupt_req <= bus_error;
			maint_interject <= !isolated && (bus_error || sel_maint);
			op_interject <= !isolated && sel_op;
		end
	end

	// Single-word transfers only: no block or client-to-client cycles exist
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state <= aux_bridge_pkg::ST_IDLE;
			dma_valid <= 1'b0;
			dma_write <= 1'b0;
			dma_addr <= '0;
			dma_wdata <= '0;
			from_diag <= 1'b0;
			dma_read <= '0;
			reply_q <= '0;
			ack_q <= 2'h0;
		end else begin
			ack_q <= 2'h0;
			unique case (state)
				aux_bridge_pkg::ST_IDLE: begin
					if (dma_start) begin
						state <= aux_bridge_pkg::ST_ISSUE;
						dma_valid <= 1'b1;
						dma_write <= start_wr;
						dma_addr <= {upper_addr, start_addr};
						dma_wdata <= {8'h00, start_data};
						from_diag <= !client_go;
					end
				end
				aux_bridge_pkg::ST_ISSUE: begin
					if (dma_done) begin
						state <= aux_bridge_pkg::ST_REPLY;
						dma_valid <= 1'b0;
						if (!dma_write) begin
							reply_q <= dma_rdata[aux_bridge_pkg::AUX_DATA_W-1:0];
							dma_read <= dma_rdata[aux_bridge_pkg::AUX_DATA_W-1:0];
						end
					end
				end
				aux_bridge_pkg::ST_REPLY: begin
					// One acknowledge per client request, none for a diagnostic one, then back to idle, where no start comes while the ack is out
					state <= aux_bridge_pkg::ST_IDLE;
					if (!from_diag)
						ack_q <= bus_sel ? 2'h2 : 2'h1;
				end
			endcase
		end
	end
endmodule : aux_bus_bridge

// *** rtl/aux_bridge_pkg.sv ***
package aux_bridge_pkg;
	localparam int AUX_ADDR_W = 22;
	localparam int AUX_DATA_W = 24;
	localparam int HOST_ADDR_W = 30;
	localparam int HOST_DATA_W = 32;
	localparam int UPPER_W = 8;
	localparam int MMIO_ADDR_W = 8;
	// Bridge registers, one word each
	localparam logic [7:0] REG_UPPER_ADDR = 8'h00;
	localparam logic [7:0] REG_CONTROL = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_ISO_REPLY = 8'h0C;
	localparam logic [7:0] REG_DIAG_ADDR = 8'h10;
	localparam logic [7:0] REG_DIAG_DATA = 8'h14;
	localparam logic [7:0] REG_DMA_READ = 8'h18;
	localparam int CTL_BUS_SEL = 0;
	localparam int CTL_DIAG_MODE = 1;
	localparam int CTL_DIAG_START = 2;
	localparam int CTL_DIAG_WRITE = 3;
	localparam int CTL_ISO_SEND = 4;
	localparam int STS_BUSY = 0;
	localparam int STS_UPPER_LOADED = 1;
	localparam int STS_ERROR = 2;
	localparam int STS_ISO_VALID = 3;
	localparam int STS_ISOLATED = 4;
	localparam logic [UPPER_W-1:0] UPPER_RESET = 8'h00;
	// Client registers over AXI4-Lite
	localparam logic [7:0] CREG_CONTROL = 8'h00;
	localparam logic [7:0] CREG_STORE_ADDR = 8'h04;
	localparam logic [7:0] CREG_WRITE_DATA = 8'h08;
	localparam logic [7:0] CREG_STATUS = 8'h0C;
	localparam logic [7:0] CREG_READ_DATA = 8'h10;
	localparam logic [7:0] CREG_ISO_ANSWER = 8'h14;
	localparam int CCTL_ACTIVE = 0;
	localparam int CCTL_BUS_SEL = 1;
	localparam int CCTL_START = 2;
	localparam int CCTL_WRITE = 3;
	localparam int CCTL_OP_INTERJECT = 4;
	localparam int CCTL_MAINT_INTERJECT = 5;
	localparam int CS_BUSY = 0;
	localparam int CS_DONE = 1;
	localparam int CS_ISO_SEEN = 2;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	typedef enum {ST_IDLE, ST_ISSUE, ST_REPLY} dma_state_t;
endpackage : aux_bridge_pkg

// *** rtl/aux_unit_bus_if.sv ***
`timescale 1ns/100ps
interface aux_unit_bus_if;
	logic dma_req;
	logic dma_write;
	logic [aux_bridge_pkg::AUX_ADDR_W-1:0] store_addr;
	logic [aux_bridge_pkg::AUX_DATA_W-1:0] write_data;
	logic [aux_bridge_pkg::AUX_DATA_W-1:0] reply_data;
	logic dma_ack;
	logic op_interject_req;
	logic maint_interject_req;
	logic iso_pulse;
	logic [aux_bridge_pkg::AUX_DATA_W-1:0] iso_reply;
	logic iso_reply_valid;
	modport bridge_end(
		input dma_req, dma_write, store_addr, write_data,
		input op_interject_req, maint_interject_req, iso_reply, iso_reply_valid,
		output reply_data, dma_ack, iso_pulse
	);
	modport client_end(
		output dma_req, dma_write, store_addr, write_data,
		output op_interject_req, maint_interject_req, iso_reply, iso_reply_valid,
		input reply_data, dma_ack, iso_pulse
	);
endinterface : aux_unit_bus_if

// *** rtl/aux_client_end.sv ***
`timescale 1ns/100ps
module aux_client_end #(
	parameter bit UNIT_NUM = 1'b0
) (
	input wire logic core_clk,
	input wire logic rstn,
	aux_unit_bus_if.client_end bus,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic active, bus_sel, dir_write, busy, done, iso_seen;
	logic [aux_bridge_pkg::AUX_ADDR_W-1:0] store_addr;
	logic [aux_bridge_pkg::AUX_DATA_W-1:0] write_data, read_data, iso_answer;
	logic op_q, maint_q, iso_valid_q;
	logic [7:0] rd_addr;
	// Unit sits only on its own bus; it talks only while its select matches it
	wire on_bus = active && (bus_sel == UNIT_NUM);
	wire wr_go = s_axi_awready && s_axi_wready;
	wire wr_full = (s_axi_wstrb == 4'hF);
	wire wr_ctl = wr_go && wr_full && (s_axi_awaddr == aux_bridge_pkg::CREG_CONTROL);
	// A control word that activates and starts at once must act on its own select bits
	wire ctl_on = s_axi_wdata[aux_bridge_pkg::CCTL_ACTIVE]
		&& (s_axi_wdata[aux_bridge_pkg::CCTL_BUS_SEL] == UNIT_NUM);
	wire next_on = wr_ctl ? ctl_on : on_bus;
	wire start_go = wr_ctl && s_axi_wdata[aux_bridge_pkg::CCTL_START] && !busy;
	wire [31:0] status_word = {29'h0, iso_seen, done, busy};
	wire [31:0] rd_word =
		(rd_addr == aux_bridge_pkg::CREG_CONTROL) ? {28'h0, dir_write, 1'b0, bus_sel, active} :
		(rd_addr == aux_bridge_pkg::CREG_STORE_ADDR) ? {10'h0, store_addr} :
		(rd_addr == aux_bridge_pkg::CREG_WRITE_DATA) ? {8'h00, write_data} :
		(rd_addr == aux_bridge_pkg::CREG_STATUS) ? status_word :
		(rd_addr == aux_bridge_pkg::CREG_READ_DATA) ? {8'h00, read_data} :
		(rd_addr == aux_bridge_pkg::CREG_ISO_ANSWER) ? {8'h00, iso_answer} : 32'h0;

	assign bus.dma_req = busy;
	assign bus.dma_write = dir_write;
	assign bus.store_addr = store_addr;
	assign bus.write_data = write_data;
	assign bus.op_interject_req = op_q;
	assign bus.maint_interject_req = maint_q;
	assign bus.iso_reply = iso_answer;
	assign bus.iso_reply_valid = iso_valid_q;
	assign s_axi_bresp = aux_bridge_pkg::AXI_OKAY;
	assign s_axi_rresp = aux_bridge_pkg::AXI_OKAY;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
		end else begin
			s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
			s_axi_bvalid <= wr_go || (s_axi_bvalid && !s_axi_bready);
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			rd_addr <= 8'h00;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid)
				rd_addr <= s_axi_araddr;
			if (s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
			end else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			active <= 1'b0;
			bus_sel <= 1'b0;
			dir_write <= 1'b0;
			store_addr <= '0;
			write_data <= '0;
			iso_answer <= '0;
		end else if (wr_go && wr_full) begin
			if (wr_ctl) begin
				active <= s_axi_wdata[aux_bridge_pkg::CCTL_ACTIVE];
				bus_sel <= s_axi_wdata[aux_bridge_pkg::CCTL_BUS_SEL];
				if (!busy)
					dir_write <= s_axi_wdata[aux_bridge_pkg::CCTL_WRITE];
			end
			if (s_axi_awaddr == aux_bridge_pkg::CREG_STORE_ADDR && !busy)
				store_addr <= s_axi_wdata[aux_bridge_pkg::AUX_ADDR_W-1:0];
			if (s_axi_awaddr == aux_bridge_pkg::CREG_WRITE_DATA && !busy)
				write_data <= s_axi_wdata[aux_bridge_pkg::AUX_DATA_W-1:0];
			if (s_axi_awaddr == aux_bridge_pkg::CREG_ISO_ANSWER)
				iso_answer <= s_axi_wdata[aux_bridge_pkg::AUX_DATA_W-1:0];
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			busy <= 1'b0;
			done <= 1'b0;
			read_data <= '0;
			op_q <= 1'b0;
			maint_q <= 1'b0;
			iso_valid_q <= 1'b0;
			iso_seen <= 1'b0;
		end else begin
			// One word per request; the request drops the cycle after the acknowledge
			if (busy && bus.dma_ack) begin
				busy <= 1'b0;
				done <= 1'b1;
				if (!dir_write)
					read_data <= bus.reply_data;
			end else if (start_go && next_on) begin
				busy <= 1'b1;
				done <= 1'b0;
			end
			op_q <= wr_ctl && next_on && s_axi_wdata[aux_bridge_pkg::CCTL_OP_INTERJECT];
			maint_q <= wr_ctl && next_on && s_axi_wdata[aux_bridge_pkg::CCTL_MAINT_INTERJECT];
			iso_valid_q <= bus.iso_pulse && on_bus;
			if (bus.iso_pulse && on_bus)
				iso_seen <= 1'b1;
			else if (start_go)
				iso_seen <= 1'b0;
		end
	end
endmodule : aux_client_end

// *** test/aux_bridge_asserts.sv ***
`timescale 1ns/100ps
module aux_bridge_asserts (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic dma_req,
	input wire logic [21:0] store_addr,
	input wire logic dma_ack,
	input wire logic op_interject_req,
	input wire logic iso_pulse,
	input wire logic dma_valid,
	input wire logic [29:0] dma_addr,
	input wire logic [31:0] dma_wdata,
	input wire logic dma_done,
	input wire logic bus_error,
	input wire logic interrupt_req,
	input wire logic op_interject,
	input wire logic mmio_req,
	input wire logic mmio_ack
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	upper_zero_a: assert property (dma_valid |-> dma_wdata[31:24] == 8'h00)
		else $error("DMA upper byte not zero");
	low_addr_a: assert property ($rose(dma_valid) && $past(dma_req)
		|-> dma_addr[21:0] == $past(store_addr)) else $error("DMA low address wrong");
	dma_hold_a: assert property (dma_valid && !dma_done |=> dma_valid && $stable(dma_addr))
		else $error("DMA request not held");
	ack_gap_a: assert property ($rose(dma_ack) |-> $past(dma_done, 2))
		else $error("Client ack without finished transfer");
	ack_pulse_a: assert property (dma_ack |=> !dma_ack)
		else $error("Client ack longer than one cycle");
	intr_after_a: assert property (bus_error |=> interrupt_req)
		else $error("Bus error gave no interrupt");
	intr_cause_a: assert property (interrupt_req |-> $past(bus_error))
		else $error("Interrupt without bus error");
	op_cause_a: assert property (op_interject |-> $past(op_interject_req))
		else $error("Operational interject without client request");
	ack_cause_a: assert property (mmio_ack |-> $past(mmio_req))
		else $error("Register ack without request");
	iso_pulse_a: assert property (iso_pulse |=> !iso_pulse)
		else $error("Isolation pulse too long");
endmodule : aux_bridge_asserts

// *** test/testbench.sv ***
`timescale 1ns/100ps
module testbench;
	logic core_clk, rstn, mmio_req, mmio_write, mmio_word, mmio_ack, g;
	logic dma_valid, dma_write, dma_done, bus_error, iso_in;
	logic interrupt_req, maint_interject, op_interject;
	logic [7:0] mmio_addr;
	logic [31:0] mmio_wdata, mmio_rdata, dma_wdata, dma_rdata, q;
	logic [29:0] dma_addr;
	logic [7:0] awaddr [2], araddr [2];
	logic [31:0] wdata [2], rdata [2];
	logic awvalid [2], wvalid [2], bready [2], arvalid [2], rready [2];
	logic awready [2], wready [2], bvalid [2], arready [2], rvalid [2];
	int bad_count, num_checks, cyc, op_cnt, mt_cnt, ir_cnt;
	aux_unit_bus_if bus_if [2] ();
	aux_bus_bridge aux_bus_bridge_inst (.core_clk(core_clk), .rstn(rstn),
		.bus0(bus_if[0]), .bus1(bus_if[1]), .mmio_req(mmio_req), .mmio_write(mmio_write),
		.mmio_word(mmio_word), .mmio_addr(mmio_addr), .mmio_wdata(mmio_wdata),
		.mmio_ack(mmio_ack), .mmio_rdata(mmio_rdata), .dma_valid(dma_valid),
		.dma_write(dma_write), .dma_addr(dma_addr), .dma_wdata(dma_wdata),
		.dma_done(dma_done), .dma_rdata(dma_rdata), .bus_error(bus_error), .iso_in(iso_in),
		.interrupt_req(interrupt_req), .maint_interject(maint_interject),
		.op_interject(op_interject));
	for (genvar i = 0; i < 2; i++) begin : unit
		aux_client_end #(.UNIT_NUM(i == 1)) aux_client_end_inst (.core_clk(core_clk),
			.rstn(rstn), .bus(bus_if[i]), .s_axi_awaddr(awaddr[i]),
			.s_axi_awvalid(awvalid[i]), .s_axi_awready(awready[i]), .s_axi_wdata(wdata[i]),
			.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid[i]), .s_axi_wready(wready[i]),
			.s_axi_bresp(), .s_axi_bvalid(bvalid[i]), .s_axi_bready(bready[i]),
			.s_axi_araddr(araddr[i]), .s_axi_arvalid(arvalid[i]), .s_axi_arready(arready[i]),
			.s_axi_rdata(rdata[i]), .s_axi_rresp(), .s_axi_rvalid(rvalid[i]),
			.s_axi_rready(rready[i]));
	end
	aux_bridge_asserts aux_bridge_asserts_inst (.core_clk(core_clk), .rstn(rstn),
		.dma_req(bus_if[0].dma_req), .store_addr(bus_if[0].store_addr),
		.dma_ack(bus_if[0].dma_ack),
		.op_interject_req(bus_if[0].op_interject_req || bus_if[1].op_interject_req),
		.iso_pulse(bus_if[0].iso_pulse), .dma_valid(dma_valid), .dma_addr(dma_addr),
		.dma_wdata(dma_wdata), .dma_done(dma_done), .bus_error(bus_error),
		.interrupt_req(interrupt_req), .op_interject(op_interject), .mmio_req(mmio_req),
		.mmio_ack(mmio_ack));
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (op_interject === 1'b1) op_cnt++;
		if (maint_interject === 1'b1) mt_cnt++;
		if (interrupt_req === 1'b1) ir_cnt++;
		// Ceiling well above the few hundred cycles the sequence needs
		if (cyc == 20000) begin
			bad_count++;
			end_sim();
		end
	end
	task end_sim();
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_sim
	task chk(input bit ok, input string m);
		num_checks++;
		if (!ok) begin
			bad_count++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : chk
	task mm(input logic w, input logic wd, input logic [7:0] a, input logic [31:0] d);
		int n;
		g = 1'b0;
		mmio_req <= 1'b1;
		mmio_write <= w;
		mmio_word <= wd;
		mmio_addr <= a;
		mmio_wdata <= d;
		@(posedge core_clk);
		mmio_req <= 1'b0;
		for (n = 0; n < 4 && !g; n++) begin
			@(posedge core_clk);
			g = (mmio_ack === 1'b1);
			q = mmio_rdata;
		end
	endtask : mm
	task wr(input logic [7:0] a, input logic [31:0] d);
		mm(1'b1, 1'b1, a, d);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		mm(1'b0, 1'b1, a, 32'h0);
		chk(g === 1'b1 && q === e, $sformatf("register read %h", a));
	endtask : rd
	// Waits as long as the slave needs; only the bench timeout ends a hang
	task aw(input int u, input logic [7:0] a, input logic [31:0] d);
		awaddr[u] <= a;
		wdata[u] <= d;
		awvalid[u] <= 1'b1;
		wvalid[u] <= 1'b1;
		bready[u] <= 1'b1;
		do begin
			@(posedge core_clk);
			if (awready[u] === 1'b1) awvalid[u] <= 1'b0;
			if (wready[u] === 1'b1) wvalid[u] <= 1'b0;
		end while (bvalid[u] !== 1'b1);
		bready[u] <= 1'b0;
	endtask : aw
	task ar(input int u, input logic [7:0] a, input logic [31:0] e);
		q = 32'hXXXXXXXX;
		araddr[u] <= a;
		arvalid[u] <= 1'b1;
		rready[u] <= 1'b1;
		do begin
			@(posedge core_clk);
			if (arready[u] === 1'b1) arvalid[u] <= 1'b0;
		end while (rvalid[u] !== 1'b1);
		q = rdata[u];
		rready[u] <= 1'b0;
		chk(q === e, $sformatf("client read %h", a));
	endtask : ar
	// Plays the store side; ex says whether a transfer must start at all
	task serve(input logic w, input logic [29:0] a, input logic [31:0] wd,
		input logic [31:0] r, input bit ex);
		int n;
		for (n = 0; n < 20 && dma_valid !== 1'b1; n++) @(posedge core_clk);
		chk((dma_valid === 1'b1) == ex, "dma start");
		if (dma_valid === 1'b1) begin
			chk(dma_addr === a && dma_write === w, "dma address");
			if (w) chk(dma_wdata === wd, "dma data");
			dma_done <= 1'b1;
			dma_rdata <= r;
			@(posedge core_clk);
			dma_done <= 1'b0;
			dma_rdata <= 32'h0;
			repeat (6) @(posedge core_clk);
		end
	endtask : serve
	initial begin
		{rstn, mmio_req, mmio_write, mmio_word, dma_done, bus_error, iso_in} = 7'h00;
		{mmio_addr, mmio_wdata, dma_rdata, cyc, bad_count, num_checks} = 0;
		{op_cnt, mt_cnt, ir_cnt} = 0;
		for (int i = 0; i < 2; i++) begin
			{awvalid[i], wvalid[i], bready[i], arvalid[i], rready[i]} = 5'h00;
			{awaddr[i], araddr[i], wdata[i]} = 48'h0;
		end
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		rd(aux_bridge_pkg::REG_UPPER_ADDR, 32'h0);
		rd(aux_bridge_pkg::REG_STATUS, 32'h0);
		aw(0, aux_bridge_pkg::CREG_STORE_ADDR, 32'h002ABCDE);
		aw(0, aux_bridge_pkg::CREG_WRITE_DATA, 32'hFF123456);
		aw(0, aux_bridge_pkg::CREG_CONTROL, 32'h0000000D);
		serve(1'b1, 30'h0, 32'h0, 32'h0, 0);
		mm(1'b1, 1'b0, aux_bridge_pkg::REG_UPPER_ADDR, 32'h0000003C);
		rd(aux_bridge_pkg::REG_UPPER_ADDR, 32'h0);
		wr(aux_bridge_pkg::REG_UPPER_ADDR, 32'hFFFFFFA5);
		rd(aux_bridge_pkg::REG_UPPER_ADDR, 32'h000000A5);
		serve(1'b1, {8'hA5, 22'h2ABCDE}, 32'h00123456, 32'h0, 1);
		ar(0, aux_bridge_pkg::CREG_STATUS, 32'h00000002);
		aw(0, aux_bridge_pkg::CREG_CONTROL, 32'h00000005);
		serve(1'b0, {8'hA5, 22'h2ABCDE}, 32'h0, 32'hFF654321, 1);
		ar(0, aux_bridge_pkg::CREG_READ_DATA, 32'h00654321);
		rd(aux_bridge_pkg::REG_DMA_READ, 32'h00654321);
		aw(0, aux_bridge_pkg::CREG_CONTROL, 32'h00000011);
		aw(0, aux_bridge_pkg::CREG_CONTROL, 32'h00000021);
		repeat (3) @(posedge core_clk);
		chk(op_cnt == 1 && mt_cnt == 1, "interjects");
		bus_error <= 1'b1;
		@(posedge core_clk);
		bus_error <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk(ir_cnt == 1 && mt_cnt == 2 && op_cnt == 1, "error events");
		rd(aux_bridge_pkg::REG_STATUS, 32'h00000006);
		rd(aux_bridge_pkg::REG_STATUS, 32'h00000002);
		aw(0, aux_bridge_pkg::CREG_ISO_ANSWER, 32'h00ABCDEF);
		wr(aux_bridge_pkg::REG_CONTROL, 32'h00000010);
		repeat (4) @(posedge core_clk);
		rd(aux_bridge_pkg::REG_STATUS, 32'h0000000A);
		rd(aux_bridge_pkg::REG_ISO_REPLY, 32'h00ABCDEF);
		rd(aux_bridge_pkg::REG_STATUS, 32'h00000002);
		// Mate stays idle while unit 1 works
		aw(0, aux_bridge_pkg::CREG_CONTROL, 32'h0);
		aw(1, aux_bridge_pkg::CREG_STORE_ADDR, 32'h00001234);
		aw(1, aux_bridge_pkg::CREG_WRITE_DATA, 32'h00C0FFEE);
		aw(1, aux_bridge_pkg::CREG_CONTROL, 32'h0000000F);
		serve(1'b1, 30'h0, 32'h0, 32'h0, 0);
		wr(aux_bridge_pkg::REG_CONTROL, 32'h00000001);
		serve(1'b1, {8'hA5, 22'h001234}, 32'h00C0FFEE, 32'h0, 1);
		ar(1, aux_bridge_pkg::CREG_STATUS, 32'h00000002);
		wr(aux_bridge_pkg::REG_DIAG_ADDR, 32'h0000ABCD);
		wr(aux_bridge_pkg::REG_DIAG_DATA, 32'h00777777);
		wr(aux_bridge_pkg::REG_CONTROL, 32'h0000000F);
		serve(1'b1, {8'hA5, 22'h00ABCD}, 32'h00777777, 32'h0, 1);
		wr(aux_bridge_pkg::REG_CONTROL, 32'h0);
		rd(8'hFC, 32'h0);
		iso_in <= 1'b1;
		@(posedge core_clk);
		iso_in <= 1'b0;
		repeat (2) @(posedge core_clk);
		mm(1'b0, 1'b1, aux_bridge_pkg::REG_UPPER_ADDR, 32'h0);
		chk(g === 1'b0, "isolated bridge answered");
		aw(1, aux_bridge_pkg::CREG_CONTROL, 32'h0);
		aw(0, aux_bridge_pkg::CREG_CONTROL, 32'h0000000D);
		serve(1'b1, 30'h0, 32'h0, 32'h0, 0);
		aw(0, aux_bridge_pkg::CREG_CONTROL, 32'h00000011);
		repeat (3) @(posedge core_clk);
		chk(op_cnt == 1, "isolated interject");
		end_sim();
	end
endmodule : testbench
